/* File: design/prv_fetch.sv */
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps

// Function
// - Reads only target own drive object
// - New job only on request rising edge
// - Job-active flag held whole job
// - Completion latency variable, never assumed
// - Edges during active job are ignored
// - Success sets done flag and value
// - Value held until next successful read
// - Failure sets failed flag
// - Failure leaves value unchanged
// - Failure code copied from service answer
// - One job per instance; instances independent
// - Reset clears flags, value and code
// - Real, int32 or int16 value variants
module prv_fetch #(
  parameter prv_pkg::prv_kind_t               VALUE_KIND   = prv_pkg::PRV_KIND_REAL,
  parameter logic [prv_pkg::PRV_OBJ_W-1:0]    LOCAL_OBJECT = 8'h00,
  parameter int unsigned                      VAL_W        =
    (VALUE_KIND == prv_pkg::PRV_KIND_INT16) ? 16 : 32
) (
  input  wire logic                           core_clk,
  input  wire logic                           srst,
  // Register bus
  input  wire logic [4:0]                     avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  input  wire logic [3:0]                     avs_byteenable,
  output logic      [31:0]                    avs_readdata,
  output logic                                avs_waitrequest,
  output logic                                irq,
  // Requesting application
  input  wire logic                           read_request,
  input  wire logic [prv_pkg::PRV_NUM_W-1:0]  setting_number,
  input  wire logic [prv_pkg::PRV_SUB_W-1:0]  setting_subindex,
  output logic                                job_active,
  output logic                                job_done,
  output logic                                job_failed,
  output logic      [prv_pkg::PRV_CODE_W-1:0] failure_code,
  output logic      [VAL_W-1:0]               fetched_value,
  // Parameter service of the local drive object
  output logic                                svc_req,
  output logic      [prv_pkg::PRV_OBJ_W-1:0]  svc_object,
  output logic      [prv_pkg::PRV_NUM_W-1:0]  svc_number,
  output logic      [prv_pkg::PRV_SUB_W-1:0]  svc_subindex,
  input  wire logic                           svc_ack,
  input  wire logic                           svc_ok,
  input  wire logic [prv_pkg::PRV_SVC_W-1:0]  svc_value,
  input  wire logic [prv_pkg::PRV_CODE_W-1:0] svc_code
);

  prv_pkg::prv_state_t              state_r;
  prv_pkg::prv_state_t              state_nxt;
  logic                             req_rise;
  logic                             start;
  logic                             finish;
  logic                             enable_r;
  logic [prv_pkg::PRV_EVT_W-1:0]    events;
  logic [prv_pkg::PRV_EVT_W-1:0]    irq_stat_r;
  logic [prv_pkg::PRV_EVT_W-1:0]    irq_mask_r;
  logic                             bus_req;
  logic                             bus_ack_r;
  logic                             bus_take;
  logic                             wr_take;
  logic                             rd_wait;
  logic [31:0]                      rd_mux;
  logic [31:0]                      value_ext;
  logic [prv_pkg::PRV_NUM_W-1:0]    last_number_r;
  logic [prv_pkg::PRV_SUB_W-1:0]    last_subindex_r;
  logic [VAL_W-1:0]                 svc_value_cut;
  logic                             ans_good;
  logic                             ans_bad;
  logic                             edge_dropped;
  logic                             is_busy;
  logic                             wr_ctrl;
  logic                             wr_mask;
  logic                             irq_clr;

  // Request edge detection

  // Level request turned into a start pulse
  prv_rise u_rise (
    .core_clk (core_clk),
    .srst     (srst),
    .level    (read_request),
    .rise     (req_rise)
  );

  // Only an edge in idle starts a job; a busy instance drops it
  assign is_busy      = (state_r == prv_pkg::PRV_BUSY);
  assign start        = req_rise & enable_r & ~is_busy;
  assign finish       = svc_ack & is_busy;
  assign edge_dropped = req_rise & is_busy;

  // Answer split by outcome, only meaningful in the answer cycle
  assign ans_good     = finish & svc_ok;
  assign ans_bad      = finish & ~svc_ok;

  // Job sequencer

  // Next state: wait for the service answer however long it takes
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      prv_pkg::PRV_IDLE:
      begin
        if (start)
          state_nxt = prv_pkg::PRV_BUSY;
      end
      prv_pkg::PRV_BUSY:
      begin
        if (finish)
          state_nxt = prv_pkg::PRV_IDLE;
      end
      default:
        state_nxt = prv_pkg::PRV_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (srst)
      state_r <= prv_pkg::PRV_IDLE;
    else
      state_r <= state_nxt;
  end

  // Job-active flag, high from accept until the answer cycle
  always_ff @(posedge core_clk)
  begin
    if (srst)
      job_active <= 1'b0;
    else if (start)
      job_active <= 1'b1;
    else if (finish)
      job_active <= 1'b0;
  end

  // Service request

  // Request held for the whole job so the service may answer late
  assign svc_req    = job_active;
  // Target is fixed to the own drive object, no input can change it
  assign svc_object = LOCAL_OBJECT;

  // Number and subindex frozen at accept time
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      svc_number   <= '0;
      svc_subindex <= '0;
    end
    else if (start)
    begin
      svc_number   <= setting_number;
      svc_subindex <= setting_subindex;
    end
  end

  // Copy of the last requested number and subindex for software
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      last_number_r   <= '0;
      last_subindex_r <= '0;
    end
    else if (finish)
    begin
      last_number_r   <= svc_number;
      last_subindex_r <= svc_subindex;
    end
  end

  // Result outputs

  // Success flag: cleared on accept, set on a good answer
  always_ff @(posedge core_clk)
  begin
    if (srst)
      job_done <= 1'b0;
    else if (start)
      job_done <= 1'b0;
    else if (ans_good)
      job_done <= 1'b1;
  end

  // Failure flag: cleared on accept, set on a bad answer
  always_ff @(posedge core_clk)
  begin
    if (srst)
      job_failed <= 1'b0;
    else if (start)
      job_failed <= 1'b0;
    else if (ans_bad)
      job_failed <= 1'b1;
  end

  // Failure code taken from the service answer
  always_ff @(posedge core_clk)
  begin
    if (srst)
      failure_code <= prv_pkg::PRV_RST_CODE;
    else if (start)
      failure_code <= prv_pkg::PRV_RST_CODE;
    else if (ans_bad)
      failure_code <= svc_code;
  end

  // Service word narrowed to the variant width
  assign svc_value_cut = svc_value[VAL_W-1:0];

  // Value only moves on a good answer; failures keep the old one
  always_ff @(posedge core_clk)
  begin
    if (srst)
      fetched_value <= '0;
    else if (ans_good)
      fetched_value <= svc_value_cut;
  end

  // Interrupt events

  // Done, failed, and request edge dropped while busy
  always_comb
  begin
    events                         = '0;
    events[prv_pkg::PRV_EV_DONE]    = ans_good;
    events[prv_pkg::PRV_EV_FAILED]  = ans_bad;
    events[prv_pkg::PRV_EV_IGNORED] = edge_dropped;
  end

  // Sticky status, cleared by a read of its register
  prv_sticky #(
    .W (prv_pkg::PRV_EVT_W)
  ) u_irq_stat (
    .core_clk (core_clk),
    .srst     (srst),
    .set      (events),
    .clear    (irq_clr),
    .flags_r  (irq_stat_r)
  );

  // Level interrupt while any unmasked bit stands
  assign irq = |(irq_stat_r & irq_mask_r);

  // Avalon-MM slave, one wait state per access

  // Handshake: wait cycle first, then the access is taken
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack_r;
  assign bus_take        = bus_req & bus_ack_r;
  assign wr_take         = bus_take & avs_write;
  assign rd_wait         = avs_read & ~bus_ack_r;

  // Strobes; status clear rides with the read-data capture so no event is lost
  assign wr_ctrl         = wr_take & (avs_address == prv_pkg::PRV_OFS_CTRL) & avs_byteenable[0];
  assign wr_mask         = wr_take & (avs_address == prv_pkg::PRV_OFS_IRQMSK) & avs_byteenable[0];
  assign irq_clr         = rd_wait & (avs_address == prv_pkg::PRV_OFS_IRQST);

  // Acknowledge toggles high for one cycle after a request appears
  always_ff @(posedge core_clk)
  begin
    if (srst)
      bus_ack_r <= 1'b0;
    else
      bus_ack_r <= bus_req & ~bus_ack_r;
  end

  // Control register: request-edge enable, low byte lane only
  always_ff @(posedge core_clk)
  begin
    if (srst)
      enable_r <= prv_pkg::PRV_RST_CTRL[prv_pkg::PRV_CTRL_EN];
    else if (wr_ctrl)
      enable_r <= avs_writedata[prv_pkg::PRV_CTRL_EN];
  end

  // Interrupt mask register
  always_ff @(posedge core_clk)
  begin
    if (srst)
      irq_mask_r <= prv_pkg::PRV_RST_MASK;
    else if (wr_mask)
      irq_mask_r <= avs_writedata[prv_pkg::PRV_EVT_W-1:0];
  end

  // Value widened to the bus, int16 sign-extended
  always_comb
  begin
    value_ext = prv_pkg::PRV_RD_ZERO;
    if (VAL_W < 32)
      value_ext = 32'($signed(fetched_value));
    else
      value_ext = 32'(fetched_value);
  end

  // Read multiplexer, unmapped addresses read zero
  always_comb
  begin
    rd_mux = prv_pkg::PRV_RD_ZERO;
    case (avs_address)
      prv_pkg::PRV_OFS_CTRL:
        rd_mux[prv_pkg::PRV_CTRL_EN] = enable_r;
      prv_pkg::PRV_OFS_STATUS:
      begin
        rd_mux[prv_pkg::PRV_ST_ACTIVE] = job_active;
        rd_mux[prv_pkg::PRV_ST_DONE]   = job_done;
        rd_mux[prv_pkg::PRV_ST_FAILED] = job_failed;
      end
      prv_pkg::PRV_OFS_VALUE:
        rd_mux = value_ext;
      prv_pkg::PRV_OFS_CODE:
        rd_mux[prv_pkg::PRV_CODE_W-1:0] = failure_code;
      prv_pkg::PRV_OFS_IRQST:
        rd_mux[prv_pkg::PRV_EVT_W-1:0] = irq_stat_r;
      prv_pkg::PRV_OFS_IRQMSK:
        rd_mux[prv_pkg::PRV_EVT_W-1:0] = irq_mask_r;
      prv_pkg::PRV_OFS_LAST:
        rd_mux = {last_subindex_r, last_number_r};
      default:
        rd_mux = prv_pkg::PRV_RD_ZERO;
    endcase
  end

  // Read data registered in the wait cycle, stands at the ack edge
  always_ff @(posedge core_clk)
  begin
    if (srst)
      avs_readdata <= prv_pkg::PRV_RD_ZERO;
    else if (rd_wait)
      avs_readdata <= rd_mux;
  end

endmodule // prv_fetch

/* File: design/prv_pkg.sv */
package prv_pkg;

  // Value type carried by one instance
  typedef enum logic [1:0] {
    PRV_KIND_REAL,
    PRV_KIND_INT32,
    PRV_KIND_INT16
  } prv_kind_t;

  // Job sequencer states
  typedef enum logic [0:0] {
    PRV_IDLE,
    PRV_BUSY
  } prv_state_t;

  // Widths of the request and answer fields
  localparam int unsigned PRV_NUM_W      = 16;
  localparam int unsigned PRV_SUB_W      = 16;
  localparam int unsigned PRV_SVC_W      = 32;
  localparam int unsigned PRV_CODE_W     = 16;
  localparam int unsigned PRV_OBJ_W      = 8;
  localparam int unsigned PRV_EVT_W      = 3;

  // Register byte offsets
  localparam logic [4:0]  PRV_OFS_CTRL   = 5'h00;
  localparam logic [4:0]  PRV_OFS_STATUS = 5'h04;
  localparam logic [4:0]  PRV_OFS_VALUE  = 5'h08;
  localparam logic [4:0]  PRV_OFS_CODE   = 5'h0C;
  localparam logic [4:0]  PRV_OFS_IRQST  = 5'h10;
  localparam logic [4:0]  PRV_OFS_IRQMSK = 5'h14;
  localparam logic [4:0]  PRV_OFS_LAST   = 5'h18;

  // Field positions
  localparam int unsigned PRV_CTRL_EN    = 0;
  localparam int unsigned PRV_ST_ACTIVE  = 0;
  localparam int unsigned PRV_ST_DONE    = 1;
  localparam int unsigned PRV_ST_FAILED  = 2;
  localparam int unsigned PRV_EV_DONE    = 0;
  localparam int unsigned PRV_EV_FAILED  = 1;
  localparam int unsigned PRV_EV_IGNORED = 2;
  localparam int unsigned PRV_LAST_SUB   = 16;

  // Reset values
  localparam logic [31:0] PRV_RST_CTRL   = 32'h0000_0001;
  localparam logic [2:0]  PRV_RST_MASK   = 3'h0;
  localparam logic [15:0] PRV_RST_CODE   = 16'h0000;
  localparam logic [31:0] PRV_RD_ZERO    = 32'h0000_0000;

endpackage

/* File: design/prv_rise.sv */
`timescale 1ns/1ps

// One-cycle pulse on each low-to-high change of a level
module prv_rise (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic level,
  output logic      rise
);

  logic level_r;

  // Previous sample, low after reset so a held-high level counts once
  always_ff @(posedge core_clk)
  begin
    if (srst)
      level_r <= 1'b0;
    else
      level_r <= level;
  end

  assign rise = level & ~level_r;

endmodule // prv_rise

/* File: design/prv_sticky.sv */
`timescale 1ns/1ps

// Sticky event bits; a new event wins over a clear in the same cycle
module prv_sticky #(
  parameter int unsigned W = 3
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] set,
  input  wire logic         clear,
  output logic      [W-1:0] flags_r
);

  // Set beats clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
      flags_r <= '0;
    else if (clear)
      flags_r <= set;
    else
      flags_r <= flags_r | set;
  end

endmodule // prv_sticky

/* File: testbench/prv_fetch_checker.sv */
`timescale 1ns/1ps

// Job sequencing checks at the requester and service ports
module prv_fetch_checker #(
  parameter int unsigned VAL_W        = 32,
  parameter logic [7:0]  LOCAL_OBJECT = 8'h00
) (
  input wire logic             core_clk,
  input wire logic             srst,
  input wire logic             read_request,
  input wire logic [15:0]      setting_number,
  input wire logic             job_active,
  input wire logic             job_done,
  input wire logic             job_failed,
  input wire logic [15:0]      failure_code,
  input wire logic [VAL_W-1:0] fetched_value,
  input wire logic [7:0]       svc_object,
  input wire logic [15:0]      svc_number,
  input wire logic             svc_ack,
  input wire logic             svc_ok,
  input wire logic [31:0]      svc_value,
  input wire logic [15:0]      svc_code
);
  logic [VAL_W-1:0] ans_w;
  logic             fin_ok;
  logic             fin_bad;

  // Answer decode
  assign ans_w   = svc_value[VAL_W-1:0];
  assign fin_ok  = job_active && svc_ack && svc_ok;
  assign fin_bad = job_active && svc_ack && !svc_ok;

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_start_edge: assert property (
    $rose(job_active) |-> $past(read_request) && !$past(read_request, 2)) else $error("no edge");
  chk_args_taken: assert property (
    $rose(job_active) |-> svc_number == $past(setting_number)) else $error("bad number");
  chk_accept_clear: assert property (
    $rose(job_active) |-> !job_done && !job_failed && failure_code == 16'h0000)
    else $error("flags not cleared");
  chk_busy_hold: assert property (
    job_active && !svc_ack |=> job_active && $stable(svc_number)) else $error("busy dropped");
  chk_done_flag: assert property (
    fin_ok |=> !job_active && job_done && !job_failed && fetched_value == $past(ans_w))
    else $error("bad success");
  chk_fail_flag: assert property (
    fin_bad |=> !job_active && job_failed && !job_done && failure_code == $past(svc_code))
    else $error("bad failure");
  chk_value_kept: assert property (
    !fin_ok |=> $stable(fetched_value)) else $error("value changed");
  chk_own_object: assert property (
    svc_object == LOCAL_OBJECT) else $error("foreign object");
endmodule // prv_fetch_checker

bind prv_fetch prv_fetch_checker #(.VAL_W(VAL_W), .LOCAL_OBJECT(LOCAL_OBJECT)) chk_inst (
  .core_clk(core_clk), .srst(srst), .read_request(read_request),
  .setting_number(setting_number), .job_active(job_active), .job_done(job_done),
  .job_failed(job_failed), .failure_code(failure_code), .fetched_value(fetched_value),
  .svc_object(svc_object), .svc_number(svc_number), .svc_ack(svc_ack), .svc_ok(svc_ok),
  .svc_value(svc_value), .svc_code(svc_code));

/* File: testbench/prv_fetch_tb.sv */
`timescale 1ns/1ps

// Bench for the int16 variant with a service model
module prv_fetch_tb;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd, svc_value, plan_value;
  logic        avs_waitrequest, irq, job_active, job_done, job_failed;
  logic        read_request = 1'b0;
  logic [15:0] setting_number = 16'h0000;
  logic [15:0] setting_subindex = 16'h0000;
  logic [15:0] failure_code, fetched_value, svc_number, svc_subindex, svc_code, plan_code;
  logic        svc_req, svc_ack, svc_ok, plan_ok;
  logic [7:0]  svc_object, plan_delay;
  logic [15:0] last_val = 16'h0000;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cyc = 0;

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  prv_fetch #(.VALUE_KIND(prv_pkg::PRV_KIND_INT16)) prv_fetch_inst (
    .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .read_request(read_request), .setting_number(setting_number),
    .setting_subindex(setting_subindex), .job_active(job_active), .job_done(job_done),
    .job_failed(job_failed), .failure_code(failure_code), .fetched_value(fetched_value),
    .svc_req(svc_req), .svc_object(svc_object), .svc_number(svc_number),
    .svc_subindex(svc_subindex), .svc_ack(svc_ack), .svc_ok(svc_ok),
    .svc_value(svc_value), .svc_code(svc_code));

  prv_svc_model prv_svc_model_inst (
    .core_clk(core_clk), .srst(srst), .svc_req(svc_req), .plan_delay(plan_delay),
    .plan_ok(plan_ok), .plan_value(plan_value), .plan_code(plan_code), .svc_ack(svc_ack),
    .svc_ok(svc_ok), .svc_value(svc_value), .svc_code(svc_code));

  // Comparisons
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus transfer held until waitrequest is low at an edge
  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    logic w;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
    begin
      @(posedge core_clk);
      w  = avs_waitrequest;
      rd = avs_readdata;
    end while (w !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic reg_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus_xfer(1'b0, a, 32'h0000_0000);
    cmp_word(what, exp, rd);
  endtask

  // One read job; poke adds a request edge while busy
  task automatic run_job(input logic [15:0] num, input logic [15:0] sub, input logic [7:0] dly,
                         input logic ok, input logic [31:0] val, input logic [15:0] code,
                         input logic poke);
    @(posedge core_clk);
    setting_number   <= num;
    setting_subindex <= sub;
    plan_delay       <= dly;
    plan_ok          <= ok;
    plan_value       <= val;
    plan_code        <= code;
    @(posedge core_clk);
    read_request <= 1'b1;
    @(posedge core_clk);
    read_request <= 1'b0;
    #1;
    cmp_bit("accept_active", 1'b1, job_active);
    cmp_bit("accept_flags", 1'b0, job_done | job_failed);
    if (poke)
    begin
      @(posedge core_clk);
      setting_number <= ~num;
      read_request   <= 1'b1;
      @(posedge core_clk);
      read_request   <= 1'b0;
      #1;
    end
    while (job_active !== 1'b0)
    begin
      @(posedge core_clk);
      #1;
    end
    cmp_bit("done", ok, job_done);
    cmp_bit("failed", !ok, job_failed);
    if (ok)
      last_val = val[15:0];
    cmp_word("value", {16'h0000, last_val}, {16'h0000, fetched_value});
    if (!ok)
      cmp_word("code", {16'h0000, code}, {16'h0000, failure_code});
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  // Test sequence
  initial
  begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    cmp_bit("rst_flags", 1'b0, job_active | job_done | job_failed | irq);
    cmp_word("rst_out", 32'h0000_0000, {fetched_value, failure_code});
    reg_chk(5'h00, 32'h0000_0001, "ctrl_rst");
    reg_chk(5'h14, 32'h0000_0000, "mask_rst");
    bus_xfer(1'b1, 5'h1C, 32'hFFFF_FFFF);
    reg_chk(5'h1C, 32'h0000_0000, "unmapped");
    $display("test reset done");
    run_job(16'h0102, 16'h0000, 8'h05, 1'b1, 32'h1234_8123, 16'h0000, 1'b1);
    cmp_bit("irq_masked", 1'b0, irq);
    reg_chk(5'h10, 32'h0000_0005, "irq_status");
    reg_chk(5'h18, 32'h0000_0102, "last_args");
    reg_chk(5'h08, 32'hFFFF_8123, "value_sext");
    reg_chk(5'h04, 32'h0000_0002, "status_done");
    $display("test success done");
    bus_xfer(1'b1, 5'h14, 32'h0000_0002);
    run_job(16'h0300, 16'h0004, 8'h00, 1'b0, 32'hDEAD_BEEF, 16'h00A5, 1'b0);
    cmp_bit("irq_on", 1'b1, irq);
    reg_chk(5'h0C, 32'h0000_00A5, "code_reg");
    reg_chk(5'h10, 32'h0000_0002, "irq_fail");
    #1;
    cmp_bit("irq_off", 1'b0, irq);
    $display("test failure done");
    run_job(16'h0203, 16'h0007, 8'h00, 1'b1, 32'h0000_7FFF, 16'h0000, 1'b0);
    reg_chk(5'h18, 32'h0007_0203, "last_args2");
    reg_chk(5'h08, 32'h0000_7FFF, "value_pos");
    $display("test next job done");
    bus_xfer(1'b1, 5'h00, 32'h0000_0000);
    read_request <= 1'b1;
    @(posedge core_clk);
    #1;
    cmp_bit("disabled", 1'b0, job_active);
    @(posedge core_clk);
    read_request <= 1'b0;
    bus_xfer(1'b1, 5'h00, 32'h0000_0001);
    reg_chk(5'h00, 32'h0000_0001, "ctrl_back");
    $display("test disable done");
    tally_and_finish();
  end
endmodule // prv_fetch_tb

/* File: testbench/prv_svc_model.sv */
`timescale 1ns/1ps

// Parameter service of the local drive object, answering after a planned wait
module prv_svc_model (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        svc_req,
  input  wire logic [7:0]  plan_delay,
  input  wire logic        plan_ok,
  input  wire logic [31:0] plan_value,
  input  wire logic [15:0] plan_code,
  output logic             svc_ack,
  output logic             svc_ok,
  output logic      [31:0] svc_value,
  output logic      [15:0] svc_code
);
  logic [7:0] cnt_r;

  // One ack per request; answer lines scrambled outside the ack cycle
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cnt_r     <= 8'h00;
      svc_ack   <= 1'b0;
      svc_ok    <= 1'b0;
      svc_value <= 32'h0000_0000;
      svc_code  <= 16'h0000;
    end
    else if (svc_req && !svc_ack && cnt_r == plan_delay)
    begin
      cnt_r     <= 8'h00;
      svc_ack   <= 1'b1;
      svc_ok    <= plan_ok;
      svc_value <= plan_value;
      svc_code  <= plan_code;
    end
    else
    begin
      if (svc_req && !svc_ack)
        cnt_r <= cnt_r + 8'h01;
      svc_ack   <= 1'b0;
      svc_ok    <= ~svc_ok;
      svc_value <= ~svc_value;
      svc_code  <= ~svc_code;
    end
  end
endmodule // prv_svc_model
